// File: logic/sldc_pkg.sv
// Shared constants for the segment LCD drive control block.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz system clock.

package sldc_pkg;

	// ------------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------------
	// Indices are the printed offsets; byte address is four times the index.
	localparam logic [15:0] IDX_PIN_CONFIG = 16'hFFC0;
	localparam logic [15:0] IDX_DISPLAY_CONTROL = 16'hFFC1;
	localparam logic [15:0] IDX_POWER_WAVEFORM = 16'hFFC2;
	localparam int ADDR_W_MIN = 18;
	localparam logic [17:0] ADDR_PIN_CONFIG = {IDX_PIN_CONFIG, 2'h0};
	localparam logic [17:0] ADDR_DISPLAY_CONTROL = {IDX_DISPLAY_CONTROL, 2'h0};
	localparam logic [17:0] ADDR_POWER_WAVEFORM = {IDX_POWER_WAVEFORM, 2'h0};

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_PIN_CONFIG = 8'h00;
	localparam logic [7:0] RST_DISPLAY_CONTROL = 8'h80;
	localparam logic [7:0] RST_POWER_WAVEFORM = 8'h60;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	// Pin configuration register.
	localparam int DUTY_SEL_LO = 6;
	localparam int DUTY_SEL_HI = 7;
	localparam int COMMON_PARALLEL_EN = 5;
	localparam int EXPANSION_PIN_SEL = 4;
	localparam int SEG_SEL_B0 = 0;
	localparam int SEG_SEL_B3 = 3;
	// Display control register.
	localparam int DRIVE_POWER_ON = 6;
	localparam int LCD_ACTIVATE = 5;
	localparam int SHOW_RAM_DATA = 4;
	localparam int FRAME_CLK_SEL_B0 = 0;
	localparam int FRAME_CLK_SEL_B3 = 3;
	// Power and waveform register.
	localparam int WAVEFORM_AB_SEL = 7;
	localparam int BOOST_SUPPLY_SEL = 4;
	localparam int CHG_DUTY_SEL_B0 = 0;
	localparam int CHG_DUTY_SEL_B3 = 3;

	// ------------------------------------------------------------------
	// Encodings and sizes
	// ------------------------------------------------------------------
	localparam logic [1:0] DUTY_STATIC = 2'h0;
	localparam logic [1:0] DUTY_HALF = 2'h1;
	localparam logic [1:0] DUTY_THIRD = 2'h2;
	localparam logic [1:0] DUTY_QUARTER = 2'h3;
	localparam logic [3:0] CHG_ALWAYS = 4'h0;
	localparam logic [3:0] CHG_NEVER = 4'h7;
	localparam int SEG_PINS = 32;
	localparam int SEG_GROUP = 8;
	localparam int COM_PINS = 4;
	localparam int SYS_DIV_LOG_MAX = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		SLDC_WR_IDLE = 1'h0,
		SLDC_WR_RESP = 1'h1
	} sldc_wr_e;

endpackage : sldc_pkg

// File: logic/sldc_tick_gen.sv
// Operating clock tick generator: system prescaler or sub-clock divider.
// Assumes sub_clk is a slow level already synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module sldc_tick_gen #(
	parameter int PRE_W = sldc_pkg::SYS_DIV_LOG_MAX
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [3:0] clk_sel,
	input wire logic sub_clk,
	output logic tick
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic sub_prev;
		logic [1:0] sub_cnt;
		logic tick;
	} sldc_tick_s;

	sldc_tick_s s_r;
	sldc_tick_s s_nxt;
	logic sub_edge;
	logic [PRE_W-1:0] pre_mask;

	// Refuse a prescaler too short for the divide-by-256 setting.
	// Elaboration stops here instead of building a short divider.
	if (PRE_W < sldc_pkg::SYS_DIV_LOG_MAX) begin : g_pre_w_check
		$error("sldc_tick_gen: PRE_W too small");
	end

	// Low-bit mask whose all-ones state marks one tick of the system divider.
	assign pre_mask = PRE_W'((32'h2 << clk_sel[2:0]) - 32'h1);
	assign sub_edge = sub_clk & ~s_r.sub_prev;
	assign tick = s_r.tick;

	// Next state: prescaler counts only while the controller runs.
	always_comb begin
		s_nxt = s_r;
		s_nxt.sub_prev = sub_clk;
		s_nxt.tick = 1'b0;
		if (!run) begin
			s_nxt.pre = '0;
			s_nxt.sub_cnt = 2'h0;
		end else begin
			s_nxt.pre = s_r.pre + PRE_W'(1);
			if (clk_sel[3]) begin
				s_nxt.tick = ((s_r.pre & pre_mask) == pre_mask); // RULE12
			end else if (sub_edge) begin
				s_nxt.sub_cnt = s_r.sub_cnt + 2'h1;
				if (clk_sel[1]) begin
					s_nxt.tick = (s_r.sub_cnt == 2'h3); // RULE11
				end else if (clk_sel[0]) begin
					s_nxt.tick = s_r.sub_cnt[0]; // RULE11
				end else begin
					s_nxt.tick = 1'b1; // RULE11
				end
			end
		end
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_sys_div_two: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
		(tick && run && clk_sel == 4'h8) ##1 (run && clk_sel == 4'h8) |=> tick)
		else $error("system clock divide by 2 tick missing");
	chk_sub_div_one: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
		(run && clk_sel == 4'h0 && sub_edge) |=> tick)
		else $error("undivided sub-clock tick missing");

endmodule : sldc_tick_gen

`default_nettype wire

// File: logic/sldc_ctrl.sv
// Segment LCD drive control: three byte registers on AXI4-Lite and the
// pin, common, supply and split-resistance controls derived from them.
// Assumes one 200 MHz clock, synchronous inputs and a standby level input.
//
// Operation
// RULE1 - Duty field selects static, half, third, quarter
// RULE2 - Parallel bit copies waveform onto unused commons (code: static and half duty only, not third)
// RULE3 - Expansion bit turns top four pins over
// RULE4 - Segment field picks 0, 8, 16, 24, 32 drivers
// RULE5 - Expansion with zero field: other pins ports
// RULE6 - Software never combines expansion with nonzero field
// RULE7 - Power bit switches drive supply on/off
// RULE8 - Inactive or standby forces drive supply off
// RULE9 - Clearing activate halts operation, keeps registers
// RULE10 - Display bit selects blank or RAM data
// RULE11 - Clock field low: sub-clock divided 1/2/4
// RULE12 - Clock field high: system clock /2../256
// RULE13 - Waveform bit selects A or B waveform
// RULE14 - Supply bit selects main or boost regulator
// RULE15 - Charge duty: always, 1/8..6/8, never
// RULE16 - Charge duty top bit: 1/16 or 1/32
// RULE17 - Reset loads pin config 00, display 80
// RULE18 - Reset loads power/waveform register with 60
// RULE19 - Enabled display refreshes panel automatically
// RULE20 - Reads return last write, effective at once
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module sldc_ctrl #(
	parameter int ADDR_W = sldc_pkg::ADDR_W_MIN
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic standby,
	input wire logic sub_clk,
	output logic ctrl_running,
	output logic op_tick,
	output logic [1:0] duty_mode,
	output logic [3:0] com_drive,
	output logic frame_alt,
	output logic [31:0] seg_drive_mask,
	output logic exp_pins_en,
	output logic drive_supply_on,
	output logic panel_ram_sel,
	output logic waveform_b,
	output logic boost_run,
	output logic split_res_connect
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] pin_cfg;
		logic [7:0] show_ram_data_ctl;
		logic [7:0] pwr_wave;
		sldc_pkg::sldc_wr_e wst;
		logic aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [7:0] w_byte;
		logic w_lane0;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rbyte;
		logic [1:0] rresp;
		logic [1:0] phase;
		logic alt;
		logic [4:0] split_cnt;
	} sldc_ctrl_s;

	sldc_ctrl_s s_r;
	sldc_ctrl_s s_nxt;
	logic running;
	logic tick;
	logic pcfg_cmx;
	logic pcfg_sgx;
	logic [3:0] pcfg_sgs;
	logic [3:0] clk_sel;
	logic [3:0] chg_sel;
	logic [3:0] phase_oh;
	logic chg_on;

	// Refuse an address bus too narrow to reach the registers.
	// Elaboration stops here instead of decoding a truncated address.
	if (ADDR_W < sldc_pkg::ADDR_W_MIN) begin : g_addr_w_check
		$error("sldc_ctrl: ADDR_W too small");
	end

	// ------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------
	// Register index for an address: 1..3 on a hit, 0 for unmapped.
	function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] addr);
		logic [17:0] a;
		a = addr[17:0];
		if (addr != ADDR_W'(a)) begin
			reg_index = 2'h0;
		end else if (a == sldc_pkg::ADDR_PIN_CONFIG) begin
			reg_index = 2'h1;
		end else if (a == sldc_pkg::ADDR_DISPLAY_CONTROL) begin
			reg_index = 2'h2;
		end else if (a == sldc_pkg::ADDR_POWER_WAVEFORM) begin
			reg_index = 2'h3;
		end else begin
			reg_index = 2'h0;
		end
	endfunction : reg_index

	// Segment driver mask; expansion keeps every segment pin a port.
	function automatic logic [31:0] seg_mask(input logic expansion_pin_sel, input logic [3:0] sgs);
		logic [2:0] grp;
		grp = sgs[3] ? 3'h4 : {1'b0, sgs[2:1]};
		if (expansion_pin_sel) begin
			seg_mask = 32'h0; // RULE5
		end else begin
			seg_mask = ~(32'hFFFFFFFF >> (32'(grp) * sldc_pkg::SEG_GROUP)); // RULE4
		end
	endfunction : seg_mask

	// ------------------------------------------------------------------
	// Field taps
	// ------------------------------------------------------------------
	assign duty_mode = s_r.pin_cfg[sldc_pkg::DUTY_SEL_HI:sldc_pkg::DUTY_SEL_LO]; // RULE1
	assign pcfg_cmx = s_r.pin_cfg[sldc_pkg::COMMON_PARALLEL_EN];
	assign pcfg_sgx = s_r.pin_cfg[sldc_pkg::EXPANSION_PIN_SEL];
	assign pcfg_sgs = s_r.pin_cfg[sldc_pkg::SEG_SEL_B3:sldc_pkg::SEG_SEL_B0];
	assign clk_sel = s_r.show_ram_data_ctl[sldc_pkg::FRAME_CLK_SEL_B3:sldc_pkg::FRAME_CLK_SEL_B0];
	assign chg_sel = s_r.pwr_wave[sldc_pkg::CHG_DUTY_SEL_B3:sldc_pkg::CHG_DUTY_SEL_B0];

	// Activate and standby together decide whether anything runs.
	assign running = s_r.show_ram_data_ctl[sldc_pkg::LCD_ACTIVATE] & ~standby; // RULE9 RULE19
	assign ctrl_running = running;

	// ------------------------------------------------------------------
	// Operating clock
	// ------------------------------------------------------------------
	sldc_tick_gen #(
		.PRE_W(sldc_pkg::SYS_DIV_LOG_MAX)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(running),
		.clk_sel(clk_sel),
		.sub_clk(sub_clk),
		.tick(tick)
	);
	assign op_tick = tick;

	// ------------------------------------------------------------------
	// Panel side decode
	// ------------------------------------------------------------------
	// Supply and data source follow their register bits only while running; the waveform bit is passed on directly.
	assign drive_supply_on = running & s_r.show_ram_data_ctl[sldc_pkg::DRIVE_POWER_ON]; // RULE7 RULE8
	assign panel_ram_sel = running & s_r.show_ram_data_ctl[sldc_pkg::SHOW_RAM_DATA]; // RULE10
	assign waveform_b = s_r.pwr_wave[sldc_pkg::WAVEFORM_AB_SEL]; // RULE13
	assign boost_run = running & s_r.pwr_wave[sldc_pkg::BOOST_SUPPLY_SEL]; // RULE14
	assign seg_drive_mask = seg_mask(pcfg_sgx, pcfg_sgs);
	assign exp_pins_en = pcfg_sgx; // RULE3
	assign frame_alt = s_r.alt;

	// Common selection: one-hot phase, copied onto unused commons when asked in static and half duty only.
	assign phase_oh = (s_r.phase > duty_mode) ? 4'h1 : (4'h1 << s_r.phase); // RULE1
	always_comb begin
		com_drive = 4'h0;
		if (running) begin
			case (duty_mode)
				sldc_pkg::DUTY_STATIC: begin
					com_drive = pcfg_cmx ? {4{phase_oh[0]}} : {3'h0, phase_oh[0]}; // RULE2
				end
				sldc_pkg::DUTY_HALF: begin
					com_drive = pcfg_cmx ? {2{phase_oh[1:0]}} : {2'h0, phase_oh[1:0]}; // RULE2
				end
				sldc_pkg::DUTY_THIRD: begin
					com_drive = {1'b0, phase_oh[2:0]};
				end
				default: begin
					com_drive = phase_oh;
				end
			endcase
		end
	end

	// Split-resistance connection within a 32-tick window.
	always_comb begin
		chg_on = 1'b0;
		if (chg_sel[3]) begin
			chg_on = chg_sel[2] ? (s_r.split_cnt == 5'h0) : (s_r.split_cnt[3:0] == 4'h0); // RULE16
		end else if (chg_sel == sldc_pkg::CHG_ALWAYS) begin
			chg_on = 1'b1; // RULE15
		end else if (chg_sel == sldc_pkg::CHG_NEVER) begin
			chg_on = 1'b0; // RULE15
		end else begin
			chg_on = (s_r.split_cnt[2:0] < chg_sel[2:0]); // RULE15
		end
	end
	assign split_res_connect = drive_supply_on & chg_on;

	// ------------------------------------------------------------------
	// Bus handshakes
	// ------------------------------------------------------------------
	assign s_axi_awready = (s_r.wst == sldc_pkg::SLDC_WR_IDLE) & ~s_r.aw_have;
	assign s_axi_wready = (s_r.wst == sldc_pkg::SLDC_WR_IDLE) & ~s_r.w_have;
	assign s_axi_bvalid = (s_r.wst == sldc_pkg::SLDC_WR_RESP);
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = ~s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = {24'h0, s_r.rbyte};
	assign s_axi_rresp = s_r.rresp;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Capture address and data in either order.
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_byte = s_axi_wdata[7:0];
			s_nxt.w_lane0 = s_axi_wstrb[0];
		end
		case (s_r.wst)
			sldc_pkg::SLDC_WR_IDLE: begin
				if (s_r.aw_have && s_r.w_have) begin
					s_nxt.bresp = sldc_pkg::RESP_OKAY;
					s_nxt.wst = sldc_pkg::SLDC_WR_RESP;
					if (s_r.w_lane0) begin
						case (reg_index(s_r.aw_addr))
							2'h1: s_nxt.pin_cfg = s_r.w_byte; // RULE20
							2'h2: s_nxt.show_ram_data_ctl = s_r.w_byte; // RULE20
							2'h3: s_nxt.pwr_wave = s_r.w_byte; // RULE20
							default: s_nxt.bresp = sldc_pkg::RESP_SLVERR;
						endcase
					end else if (reg_index(s_r.aw_addr) == 2'h0) begin
						s_nxt.bresp = sldc_pkg::RESP_SLVERR;
					end
				end
			end
			sldc_pkg::SLDC_WR_RESP: begin
				if (s_axi_bready) begin
					s_nxt.wst = sldc_pkg::SLDC_WR_IDLE;
					s_nxt.aw_have = 1'b0;
					s_nxt.w_have = 1'b0;
				end
			end
			default: begin
				s_nxt.wst = sldc_pkg::SLDC_WR_IDLE;
			end
		endcase
		// Reads answer one cycle after the address is taken.
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = sldc_pkg::RESP_OKAY;
			case (reg_index(s_axi_araddr))
				2'h1: s_nxt.rbyte = s_r.pin_cfg; // RULE20
				2'h2: s_nxt.rbyte = s_r.show_ram_data_ctl; // RULE20
				2'h3: s_nxt.rbyte = s_r.pwr_wave; // RULE20
				default: begin
					s_nxt.rbyte = 8'h0;
					s_nxt.rresp = sldc_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Common phase, alternation and split window advance on ticks only.
		if (s_r.phase > duty_mode) begin
			s_nxt.phase = 2'h0;
		end else if (running && tick) begin // RULE9 RULE19
			s_nxt.split_cnt = s_r.split_cnt + 5'h1;
			if (s_r.phase == duty_mode) begin
				s_nxt.phase = 2'h0;
				s_nxt.alt = ~s_r.alt;
			end else begin
				s_nxt.phase = s_r.phase + 2'h1;
			end
		end
	end

	// State register with documented reset values.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.pin_cfg <= sldc_pkg::RST_PIN_CONFIG; // RULE17
			s_r.show_ram_data_ctl <= sldc_pkg::RST_DISPLAY_CONTROL; // RULE17
			s_r.pwr_wave <= sldc_pkg::RST_POWER_WAVEFORM; // RULE18
			s_r.wst <= sldc_pkg::SLDC_WR_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_duty_commons: assert property ((running && duty_mode == sldc_pkg::DUTY_THIRD) // RULE1
		|-> (com_drive[3] == 1'b0 && $onehot(com_drive)))
		else $error("third duty drives a wrong common");
	chk_com_unused_off: assert property ((!pcfg_cmx && duty_mode == sldc_pkg::DUTY_STATIC) // RULE2
		|-> com_drive[3:1] == 3'h0)
		else $error("unused commons driven without parallel");
	chk_com_parallel: assert property ((running && pcfg_cmx && duty_mode == sldc_pkg::DUTY_HALF) // RULE2
		|-> (com_drive[3:2] == com_drive[1:0] && com_drive != 4'h0))
		else $error("half duty parallel commons differ");
	chk_exp_pins: assert property (pcfg_sgx |-> (exp_pins_en && seg_drive_mask == 32'h0)) // RULE3
		else $error("expansion pins still segment drivers");
	chk_seg_all: assert property ((!pcfg_sgx && pcfg_sgs[3]) |-> seg_drive_mask == 32'hFFFFFFFF) // RULE4
		else $error("all-segment setting not honoured");
	chk_seg_top8: assert property ((!pcfg_sgx && pcfg_sgs[3:1] == 3'h1) // RULE4
		|-> seg_drive_mask == 32'hFF000000)
		else $error("top eight segment setting not honoured");
	chk_supply_forced: assert property ((!s_r.show_ram_data_ctl[sldc_pkg::LCD_ACTIVATE] || standby) // RULE8
		|-> (!drive_supply_on && !split_res_connect && !boost_run))
		else $error("drive supply on while halted");
	chk_halt_hold: assert property ((!running && $past(!running) && s_r.phase <= duty_mode) // RULE9
		|=> ($stable(s_r.phase) && $stable(s_r.alt) && !op_tick))
		else $error("controller advanced while halted");
	chk_blank_data: assert property (!s_r.show_ram_data_ctl[sldc_pkg::SHOW_RAM_DATA] |-> !panel_ram_sel) // RULE10
		else $error("RAM data shown in blank mode");
	chk_split_never: assert property ((chg_sel == sldc_pkg::CHG_NEVER) |-> !split_res_connect) // RULE15
		else $error("split resistance connected in never mode");
	chk_split_always: assert property ((drive_supply_on && chg_sel == sldc_pkg::CHG_ALWAYS) // RULE15
		|-> split_res_connect)
		else $error("split resistance open in always mode");
	chk_reset_load: assert property (!$past(aresetn) |-> (s_r.pin_cfg == 8'h00 // RULE17 RULE18
		&& s_r.show_ram_data_ctl == 8'h80 && s_r.pwr_wave == 8'h60))
		else $error("wrong register value after reset");
	chk_write_resp: assert property ((s_r.aw_have && s_r.w_have && !s_axi_bvalid) // RULE20
		|=> s_axi_bvalid [*1])
		else $error("write response not raised one cycle after data");

	cov_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == sldc_pkg::RESP_OKAY);
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
	cov_expansion: cover property (exp_pins_en && running);
	cov_quarter_wrap: cover property (running && tick && s_r.phase == sldc_pkg::DUTY_QUARTER);

endmodule : sldc_ctrl

`default_nettype wire

// File: tb/sldc_panel_model.sv
// Panel model: the commons of a segment LCD panel that record every drive.
// Assumes the common outputs are settled well before each falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module sldc_panel_model (
	input wire logic aclk,
	input wire logic clear,
	input wire logic [3:0] com_drive,
	output logic [3:0] com_seen
);
	// Records every common plate that was ever driven since the last clear.
	always @(negedge aclk) begin
		if (clear) begin
			com_seen <= 4'h0;
		end else begin
			com_seen <= com_seen | com_drive;
		end
	end
endmodule : sldc_panel_model

`default_nettype wire

// File: tb/test_segment_lcd_drive_control.sv
// Self-checking bench for the segment LCD drive control block.
// Assumes the package constants and one 200 MHz clock; the bench makes the sub-clock.
`timescale 1ns/1ps
`default_nettype none

module test_segment_lcd_drive_control;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [17:0] awa = 18'h0;
	logic [17:0] ara = 18'h0;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0, wv = 1'b0, bri = 1'b0, arv = 1'b0, rri = 1'b0;
	logic stby = 1'b0, sub = 1'b0, clr = 1'b1;
	logic awr, wr_rdy, bv, arr, rv, run, tick, exp_en, sup, ram, wb, boost, split, alt;
	logic [1:0] br, rr, duty;
	logic [3:0] com, seen;
	logic [31:0] rd, mask;
	int n_fail = 0;
	int checks = 0;
	int sub_cnt = 0;

	// The clock toggles each half period; the sub-clock rises every 16 cycles.
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		sub_cnt <= sub_cnt + 1;
		sub <= sub_cnt[3];
	end

	sldc_ctrl sldc_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bri), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rri),
		.standby(stby), .sub_clk(sub), .ctrl_running(run), .op_tick(tick),
		.duty_mode(duty), .com_drive(com), .frame_alt(alt), .seg_drive_mask(mask),
		.exp_pins_en(exp_en), .drive_supply_on(sup), .panel_ram_sel(ram),
		.waveform_b(wb), .boost_run(boost), .split_res_connect(split));
	sldc_panel_model sldc_panel_model_i (.aclk(aclk), .clear(clr), .com_drive(com),
		.com_seen(seen));

	// Compares a seen value with the expected one and counts the result.
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("Error %0t %s", $time, m);
		end
	endtask : chk

	// One AXI4-Lite write; handshakes are judged at the falling edge before the rise.
	task automatic wr(input logic [17:0] a, input logic [7:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awa <= a; wd <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; bri <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(negedge aclk);
			aw_ok = aw_ok | awr;
			w_ok = w_ok | wr_rdy;
			@(posedge aclk);
			if (aw_ok) awv <= 1'b0;
			if (w_ok) wv <= 1'b0;
		end
		do @(negedge aclk); while (bv !== 1'b1);
		r = br;
		@(posedge aclk);
		bri <= 1'b0;
	endtask : wr

	// One AXI4-Lite read.
	task automatic rdr(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		ara <= a; arv <= 1'b1; rri <= 1'b1;
		do @(negedge aclk); while (arr !== 1'b1);
		@(posedge aclk);
		arv <= 1'b0;
		do @(negedge aclk); while (rv !== 1'b1);
		d = rd;
		r = rr;
		@(posedge aclk);
		rri <= 1'b0;
	endtask : rdr

	// Reads a register and compares data and an OKAY response.
	task automatic rchk(input logic [17:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rdr(a, d, r);
		chk(d, {24'h0, e}, "read data");
		chk(r, sldc_pkg::RESP_OKAY, "read response");
	endtask : rchk

	// Counts cycles with op_tick or split connect high over a span of cycles.
	task automatic cnt(input int span, input bit pick, output int c);
		c = 0;
		repeat (span) begin
			@(negedge aclk);
			c += pick ? split : tick;
		end
	endtask : cnt

	// Measures the cycle count between two operating clock ticks.
	task automatic gap(output int c);
		c = 0;
		do @(negedge aclk); while (tick !== 1'b1);
		do begin
			@(negedge aclk);
			c++;
		end while (tick !== 1'b1);
	endtask : gap

	// Reset values and the unmapped address.
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		rchk(sldc_pkg::ADDR_PIN_CONFIG, 8'h00);
		rchk(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h80);
		rchk(sldc_pkg::ADDR_POWER_WAVEFORM, 8'h60);
		chk(run, 1'b0, "halted after reset");
		rdr(18'h00010, d, r);
		chk(r, sldc_pkg::RESP_SLVERR, "unmapped read");
		wr(18'h00010, 8'h55, r);
		chk(r, sldc_pkg::RESP_SLVERR, "unmapped write");
	endtask : t_reset

	// Every segment field and duty code, then expansion mode.
	task automatic t_pins();
		logic [1:0] r;
		logic [7:0] v;
		for (int i = 0; i < 16; i++) begin
			v = {i[1:0], 2'h0, i[3:0]};
			wr(sldc_pkg::ADDR_PIN_CONFIG, v, r);
			chk(mask, i[3] ? 32'hFFFFFFFF : ~(32'hFFFFFFFF >> (8 * i[2:1])), "mask");
			chk(duty, i[1:0], "duty");
			chk(exp_en, 1'b0, "expansion off");
			rchk(sldc_pkg::ADDR_PIN_CONFIG, v);
		end
		wr(sldc_pkg::ADDR_PIN_CONFIG, 8'h10, r);
		chk(exp_en, 1'b1, "expansion on");
		chk(mask[27:0], 28'h0, "ports beside expansion");
	endtask : t_pins

	// Commons seen by the panel per duty and paralleling.
	task automatic t_common();
		logic [1:0] r;
		logic a;
		int c;
		logic [7:0] pc [7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hC0};
		logic [3:0] ex [7] = '{4'h1, 4'hF, 4'h3, 4'hF, 4'h7, 4'h7, 4'hF};
		wr(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h68, r);
		for (int i = 0; i < 7; i++) begin
			wr(sldc_pkg::ADDR_PIN_CONFIG, pc[i], r);
			@(posedge aclk) clr <= 1'b1;
			@(posedge aclk) clr <= 1'b0;
			repeat (64) @(posedge aclk);
			chk(seen, ex[i], "commons driven");
		end
		// Quarter duty at two cycles a tick: alternation flips every eight cycles.
		@(negedge aclk);
		a = alt;
		c = 0;
		repeat (64) begin
			@(negedge aclk);
			c += (alt != a);
			a = alt;
		end
		chk(c, 8, "alternation per frame");
	endtask : t_common

	// Operating clock from the system prescaler and from the sub-clock.
	task automatic t_clock();
		logic [1:0] r;
		int c;
		for (int k = 0; k < 8; k++) begin
			wr(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h68 | k[7:0], r);
			gap(c);
			chk(c, 2 << k, "system tick period");
		end
		for (int j = 0; j < 4; j++) begin
			wr(sldc_pkg::ADDR_DISPLAY_CONTROL, (j == 3) ? 8'h66 : 8'h60 | j[7:0], r);
			gap(c);
			chk(c, 16 << ((j > 2) ? 2 : j), "sub tick period");
		end
	endtask : t_clock

	// Supply, display data, standby and halting with registers kept.
	task automatic t_halt();
		logic [1:0] r;
		int c;
		wr(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h78, r);
		chk({run, sup, ram}, 3'h7, "running");
		wr(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h68, r);
		chk(ram, 1'b0, "blank data");
		wr(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h38, r);
		chk(sup, 1'b0, "power bit off");
		wr(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h78, r);
		@(posedge aclk) stby <= 1'b1;
		@(negedge aclk);
		chk({run, sup, ram}, 3'h0, "standby");
		cnt(64, 1'b0, c);
		chk(c, 0, "no ticks in standby");
		@(posedge aclk) stby <= 1'b0;
		wr(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h58, r);
		chk(sup, 1'b0, "inactive supply");
		cnt(64, 1'b0, c);
		chk(c, 0, "no ticks inactive");
		rchk(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h58);
		rchk(sldc_pkg::ADDR_PIN_CONFIG, 8'hC0);
	endtask : t_halt

	// Waveform, boost and split-resistance duty over four whole windows.
	task automatic t_power();
		logic [1:0] r;
		int c;
		logic [3:0] cd [7] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'h8, 4'hC};
		int ex [7] = '{256, 32, 128, 192, 0, 16, 8};
		wr(sldc_pkg::ADDR_DISPLAY_CONTROL, 8'h68, r);
		for (int i = 0; i < 7; i++) begin
			wr(sldc_pkg::ADDR_POWER_WAVEFORM, {4'h9, cd[i]}, r);
			chk({wb, boost}, 2'h3, "B waveform and boost");
			cnt(256, 1'b1, c);
			chk(c, ex[i], "split duty");
		end
		wr(sldc_pkg::ADDR_POWER_WAVEFORM, 8'h07, r);
		chk({wb, boost}, 2'h0, "A waveform and main supply");
	endtask : t_power

	// Prints the verdict and ends the run.
	task automatic wrap_up();
		if (n_fail == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	// Main sequence after a three-cycle reset.
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_pins();
		t_common();
		t_clock();
		t_halt();
		t_power();
		wrap_up();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#300000;
		n_fail++;
		wrap_up();
	end
endmodule : test_segment_lcd_drive_control

`default_nettype wire
